// ### hw/clock_startup_map.svh
// Constant map for the clock source and start-up controller.
`ifndef CLOCK_STARTUP_MAP_SVH
`define CLOCK_STARTUP_MAP_SVH

// ----------------------------------------------------------------------------
// Source-select fuse codes, as stored (zero means programmed)
// ----------------------------------------------------------------------------
`define SRC_EXTERNAL 2'h0
`define SRC_INT_HALF 2'h1
`define SRC_INT_FULL 2'h2
`define SRC_LOW_FREQ 2'h3

// ----------------------------------------------------------------------------
// Start-up time fuse codes
// ----------------------------------------------------------------------------
`define SUT_NO_TIMEOUT 2'h0
`define SUT_SHORT 2'h1
`define SUT_LONG 2'h2
`define SUT_RESERVED 2'h3

// ----------------------------------------------------------------------------
// Single fuse polarity and shipped fuse values
// ----------------------------------------------------------------------------
`define FUSE_PROGRAMMED 1'b0
`define SHIPPED_SOURCE 2'h2
`define SHIPPED_STARTUP 2'h2
`define SHIPPED_DIV8 1'b0
`define SHIPPED_RESET_DISABLE 1'b1

// ----------------------------------------------------------------------------
// Start-up timing
// ----------------------------------------------------------------------------
`define RESET_DELAY_CK 14
`define WAKE_DELAY_CK 6
`define SHORT_TIMEOUT_MS 4
`define LONG_TIMEOUT_MS 64
`define SHORT_TIMEOUT_WDT 512
`define LONG_TIMEOUT_WDT 8192

// ----------------------------------------------------------------------------
// Prescaler select field and trim register
// ----------------------------------------------------------------------------
`define PRESCALE_DIV1 4'h0
`define PRESCALE_DIV8 4'h3
`define PRESCALE_MAX 4'h8
`define TRIM_VALUE_MASK 8'h7F
`define TRIM_RESET 8'h00

`endif

// ### hw/clock_startup_pkg.sv
// Types shared by the clock source and start-up controller.
package clock_startup_pkg;

    typedef enum logic [2:0] {
        ST_CAPTURE,
        ST_TIMEOUT,
        ST_RESET_CK,
        ST_RUN,
        ST_SLEEP,
        ST_WAKE_CK
    } startup_state_t;

    function automatic logic [7:0] divide_limit(input logic [3:0] sel);
        logic [8:0] factor;
        factor = 9'h001 << sel;
        return 8'(factor - 9'h001);
    endfunction

endpackage

// ### hw/edge_sync.sv
// Two-flop synchroniser with a rising-edge pulse taken after the second flop.
`timescale 1ns/100ps
module edge_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Asynchronous input
    input wire logic [WIDTH-1:0] i_async,
    // Synchronised level and rising-edge pulse
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] prev_q;

    // The sampling flops stay out of reset so that levels are settled at release.
    always_ff @(posedge i_clk) begin
        meta_q <= i_async;
        level_q <= meta_q;
        if (i_rst) begin
            prev_q <= '1;
        end else begin
            prev_q <= level_q;
        end
    end

    assign o_level = level_q;
    assign o_rise = level_q & ~prev_q;

endmodule // edge_sync

// ### hw/clock_startup_control.sv
// Clock source selection, start-up timing, trim load and system prescaler.
//
// Overview of operation
// - Source fuses pick external, internal or low-frequency.
// - Fuse stored one unprogrammed, zero programmed.
// - Code 10 full rate, 01 halved.
// - Wake from deep sleep waits six source cycles.
// - Reset time-out counts 512 or 8192 watchdog cycles.
// - Startup fuses: 14, 14+4ms, 14+64ms; 11 reserved.
// - Internal source, reset pin disabled: force 4ms.
// - One calibration byte loaded into trim during reset.
// - Watchdog oscillator still times the reset time-out.
// - Shipped fuses: full-rate internal, long delay, divide-eight.
// - Prescaler divides all synchronous clocks by one factor.
// - Converter clock may run while core halted.
// - Prescaler resets to 0011 or 0000 per fuse.
`timescale 1ns/100ps
`include "clock_startup_map.svh"
module clock_startup_control
    import clock_startup_pkg::*;
#(
    parameter int SHORT_TIMEOUT_CYCLES = `SHORT_TIMEOUT_WDT,
    parameter int LONG_TIMEOUT_CYCLES = `LONG_TIMEOUT_WDT
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Oscillator and clock pins, asynchronous
    input wire logic i_external_clock_input,
    input wire logic i_internal_oscillator,
    input wire logic i_low_freq_oscillator,
    input wire logic i_watchdog_oscillator,
    // Fuse row, asynchronous, stored polarity
    input wire logic i_fuse_valid,
    input wire logic [1:0] i_clock_source_select_fuses,
    input wire logic [1:0] i_startup_time_fuses,
    input wire logic i_divide_by_eight_fuse,
    input wire logic i_reset_pin_disable_fuse,
    input wire logic [7:0] i_calibration_byte_full,
    input wire logic [7:0] i_calibration_byte_half,
    // Core-side control, same clock
    input wire logic i_sleep_request,
    input wire logic i_wake_event,
    input wire logic i_converter_keep_running,
    input wire logic i_prescale_write,
    input wire logic [3:0] i_prescale_value,
    input wire logic i_trim_write,
    input wire logic [7:0] i_trim_value,
    // Clock enables
    output logic o_core_clock_en,
    output logic o_peripheral_clock_en,
    output logic o_program_memory_clock_en,
    output logic o_converter_clock_en,
    // Status
    output logic o_execution_enable,
    output logic [1:0] o_selected_source,
    output logic [3:0] o_prescaler_select_field,
    output logic [7:0] o_oscillator_trim_register
);

    localparam int CNT_W = $clog2(LONG_TIMEOUT_CYCLES + 1);

    // ------------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------------
    if (SHORT_TIMEOUT_CYCLES < 1 || LONG_TIMEOUT_CYCLES < SHORT_TIMEOUT_CYCLES) begin : g_chk
        $error("Time-out cycle counts must be positive and ordered.");
    end

    // ------------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------------
    logic [3:0] osc_rise;
    logic [3:0] osc_level_unused;
    logic [22:0] fuse_level;
    logic [22:0] fuse_rise_unused;

    edge_sync #(
        .WIDTH(4)
    ) u_osc_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_watchdog_oscillator, i_low_freq_oscillator,
                  i_internal_oscillator, i_external_clock_input}),
        .o_level(osc_level_unused),
        .o_rise(osc_rise)
    );

    // Fuses are static while powered, so a plain level synchroniser is enough.
    edge_sync #(
        .WIDTH(23)
    ) u_fuse_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_fuse_valid, i_clock_source_select_fuses, i_startup_time_fuses,
                  i_divide_by_eight_fuse, i_reset_pin_disable_fuse,
                  i_calibration_byte_full, i_calibration_byte_half}),
        .o_level(fuse_level),
        .o_rise(fuse_rise_unused)
    );

    logic ext_rise;
    logic osc_tick;
    logic low_rise;
    logic wdt_rise;

    assign ext_rise = osc_rise[0];
    assign osc_tick = osc_rise[1];
    assign low_rise = osc_rise[2];
    assign wdt_rise = osc_rise[3];

    // ------------------------------------------------------------------------
    // Fuse decode
    // ------------------------------------------------------------------------
    logic [1:0] fuse_src;
    logic [1:0] fuse_sut;
    logic fuse_div8;
    logic fuse_rstdis;
    logic [7:0] cal_full;

    always_comb begin
        if (fuse_level[22]) begin
            fuse_src = fuse_level[21:20];
            fuse_sut = fuse_level[19:18];
            fuse_div8 = fuse_level[17];
            fuse_rstdis = fuse_level[16];
        end else begin
            // An unwritten fuse row behaves as the device leaves the factory.
            fuse_src = `SHIPPED_SOURCE;
            fuse_sut = `SHIPPED_STARTUP;
            fuse_div8 = `SHIPPED_DIV8;
            fuse_rstdis = `SHIPPED_RESET_DISABLE;
        end
    end

    assign cal_full = fuse_level[15:8];

    // ------------------------------------------------------------------------
    // Configuration and trim
    // ------------------------------------------------------------------------
    startup_state_t state_q;
    startup_state_t state_d;
    logic [1:0] src_q;
    logic [1:0] src_d;
    logic [3:0] presc_q;
    logic [3:0] presc_d;
    logic [7:0] trim_q;
    logic [7:0] trim_d;
    logic presc_load;

    always_comb begin
        src_d = src_q;
        presc_d = presc_q;
        trim_d = trim_q;
        presc_load = 1'b0;
        if (state_q == ST_CAPTURE) begin
            src_d = fuse_src;
            // The divide-eight fuse is programmed when it stores zero.
            if (fuse_div8 == `FUSE_PROGRAMMED) begin
                presc_d = `PRESCALE_DIV8;
            end else begin
                presc_d = `PRESCALE_DIV1;
            end
            // Only the full-rate byte is loaded; the half rate shares the oscillator.
            trim_d = cal_full & `TRIM_VALUE_MASK;
            presc_load = 1'b1;
        end else begin
            // Reserved division codes are ignored rather than clamped.
            if (i_prescale_write && i_prescale_value <= `PRESCALE_MAX) begin
                presc_d = i_prescale_value;
                presc_load = 1'b1;
            end
            if (i_trim_write) begin
                trim_d = i_trim_value & `TRIM_VALUE_MASK;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            src_q <= `SRC_INT_FULL;
            presc_q <= `PRESCALE_DIV1;
            trim_q <= `TRIM_RESET;
        end else begin
            src_q <= src_d;
            presc_q <= presc_d;
            trim_q <= trim_d;
        end
    end

    // ------------------------------------------------------------------------
    // Selected source
    // ------------------------------------------------------------------------
    logic half_q;
    logic half_d;
    logic src_tick;

    always_comb begin
        half_d = half_q;
        if (osc_tick) begin
            half_d = ~half_q;
        end
        case (src_q)
            `SRC_EXTERNAL: src_tick = ext_rise;
            `SRC_INT_HALF: src_tick = osc_tick & half_q;
            `SRC_INT_FULL: src_tick = osc_tick;
            `SRC_LOW_FREQ: src_tick = low_rise;
            default: src_tick = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            half_q <= 1'b0;
        end else begin
            half_q <= half_d;
        end
    end

    // ------------------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------------------
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] tmo_limit_q;
    logic [CNT_W-1:0] tmo_limit_d;
    logic need_tmo;
    logic [CNT_W-1:0] short_last;
    logic [CNT_W-1:0] long_last;

    assign short_last = CNT_W'(SHORT_TIMEOUT_CYCLES - 1);
    assign long_last = CNT_W'(LONG_TIMEOUT_CYCLES - 1);

    always_comb begin
        need_tmo = 1'b1;
        tmo_limit_d = tmo_limit_q;
        case (fuse_sut)
            `SUT_NO_TIMEOUT: begin
                // A disabled reset pin needs time to enter programming mode.
                if (fuse_src != `SRC_EXTERNAL && fuse_rstdis == `FUSE_PROGRAMMED) begin
                    tmo_limit_d = short_last;
                end else begin
                    need_tmo = 1'b0;
                end
            end
            `SUT_SHORT: tmo_limit_d = short_last;
            `SUT_LONG: tmo_limit_d = long_last;
            default: tmo_limit_d = long_last;
        endcase
        if (state_q != ST_CAPTURE) begin
            need_tmo = 1'b0;
            tmo_limit_d = tmo_limit_q;
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_CAPTURE: begin
                cnt_d = '0;
                state_d = need_tmo ? ST_TIMEOUT : ST_RESET_CK;
            end
            ST_TIMEOUT: begin
                // The watchdog oscillator times this whatever the system source.
                if (wdt_rise) begin
                    if (cnt_q == tmo_limit_q) begin
                        cnt_d = '0;
                        state_d = ST_RESET_CK;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            ST_RESET_CK: begin
                if (src_tick) begin
                    if (cnt_q == CNT_W'(`RESET_DELAY_CK - 1)) begin
                        cnt_d = '0;
                        state_d = ST_RUN;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (i_sleep_request) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                cnt_d = '0;
                if (i_wake_event) begin
                    state_d = ST_WAKE_CK;
                end
            end
            ST_WAKE_CK: begin
                if (src_tick) begin
                    if (cnt_q == CNT_W'(`WAKE_DELAY_CK - 1)) begin
                        cnt_d = '0;
                        state_d = ST_RUN;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            default: begin
                state_d = ST_CAPTURE;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= ST_CAPTURE;
            cnt_q <= '0;
            tmo_limit_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            tmo_limit_q <= tmo_limit_d;
        end
    end

    // ------------------------------------------------------------------------
    // Prescaler and clock enables
    // ------------------------------------------------------------------------
    logic [7:0] div_q;
    logic [7:0] div_d;
    logic div_tick;
    logic core_en_d;
    logic conv_en_d;
    logic core_en_q;
    logic periph_en_q;
    logic flash_en_q;
    logic conv_en_q;
    logic exec_q;

    always_comb begin
        div_d = div_q;
        div_tick = 1'b0;
        // Restarting the count on a new factor avoids a stretched first period.
        if (presc_load) begin
            div_d = '0;
        end else if (src_tick) begin
            if (div_q >= divide_limit(presc_q)) begin
                div_d = '0;
                div_tick = 1'b1;
            end else begin
                div_d = div_q + 8'h01;
            end
        end
        core_en_d = div_tick && state_d == ST_RUN;
        conv_en_d = div_tick && (state_d == ST_RUN ||
                                 (state_d == ST_SLEEP && i_converter_keep_running));
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_q <= '0;
            core_en_q <= 1'b0;
            periph_en_q <= 1'b0;
            flash_en_q <= 1'b0;
            conv_en_q <= 1'b0;
            exec_q <= 1'b0;
        end else begin
            div_q <= div_d;
            core_en_q <= core_en_d;
            periph_en_q <= core_en_d;
            flash_en_q <= core_en_d;
            conv_en_q <= conv_en_d;
            exec_q <= state_d == ST_RUN;
        end
    end

    assign o_core_clock_en = core_en_q;
    assign o_peripheral_clock_en = periph_en_q;
    assign o_program_memory_clock_en = flash_en_q;
    assign o_converter_clock_en = conv_en_q;
    assign o_execution_enable = exec_q;
    assign o_selected_source = src_q;
    assign o_prescaler_select_field = presc_q;
    assign o_oscillator_trim_register = trim_q;

endmodule // clock_startup_control

// ### sim/osc_source_model.sv
// Free-running oscillators that feed the clock source and start-up controller.
`timescale 1ns/100ps
module osc_source_model #(
    parameter int EXT_HALF_NS = 80,
    parameter int INT_HALF_NS = 60,
    parameter int LOW_HALF_NS = 140,
    parameter int WDT_HALF_NS = 100
) (
    // Oscillator pins
    output logic o_external_clock_input,
    output logic o_internal_oscillator,
    output logic o_low_freq_oscillator,
    output logic o_watchdog_oscillator
);
    // The external period never steps, so it stays far inside the 2% limit.
    initial begin
        o_external_clock_input = 1'b0;
        #7;
        forever #(EXT_HALF_NS) o_external_clock_input = ~o_external_clock_input;
    end
    initial begin
        o_internal_oscillator = 1'b0;
        #3;
        forever #(INT_HALF_NS) o_internal_oscillator = ~o_internal_oscillator;
    end
    initial begin
        o_low_freq_oscillator = 1'b0;
        #11;
        forever #(LOW_HALF_NS) o_low_freq_oscillator = ~o_low_freq_oscillator;
    end
    // The watchdog source runs whatever the selected chip clock is.
    initial begin
        o_watchdog_oscillator = 1'b0;
        #5;
        forever #(WDT_HALF_NS) o_watchdog_oscillator = ~o_watchdog_oscillator;
    end
endmodule // osc_source_model

// ### sim/clock_startup_control_checker.sv
// Port-level assertions for the clock source and start-up controller.
`timescale 1ns/100ps
module clock_startup_control_checker #(
    parameter int SHORT_TIMEOUT_CYCLES = 512,
    parameter int LONG_TIMEOUT_CYCLES = 8192
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Core-side control
    input wire logic i_sleep_request,
    input wire logic i_converter_keep_running,
    input wire logic i_prescale_write,
    input wire logic [3:0] i_prescale_value,
    input wire logic i_trim_write,
    input wire logic [7:0] i_trim_value,
    // Design outputs
    input wire logic o_core_clock_en,
    input wire logic o_peripheral_clock_en,
    input wire logic o_program_memory_clock_en,
    input wire logic o_converter_clock_en,
    input wire logic o_execution_enable,
    input wire logic [1:0] o_selected_source,
    input wire logic [3:0] o_prescaler_select_field,
    input wire logic [7:0] o_oscillator_trim_register
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    reset_clear_a: assert property ($fell(i_rst) |-> !o_execution_enable
        && !o_core_clock_en && o_prescaler_select_field == 4'h0) else $error("Reset not clear.");
    startup_hold_a: assert property ($fell(i_rst) |-> (!o_execution_enable) [*8])
        else $error("Execution began too early.");
    core_run_only_a: assert property (o_core_clock_en |-> o_execution_enable)
        else $error("Core clock outside run.");
    enables_agree_a: assert property (o_core_clock_en == o_peripheral_clock_en
        && o_core_clock_en == o_program_memory_clock_en) else $error("Clock enables differ.");
    run_agree_a: assert property (o_execution_enable |-> o_converter_clock_en == o_core_clock_en)
        else $error("Converter differs in run.");
    converter_keep_a: assert property (o_converter_clock_en && !o_execution_enable
        |-> i_converter_keep_running || $past(i_converter_keep_running)) else $error("Converter ran.");
    sleep_stop_a: assert property (o_execution_enable && i_sleep_request
        |=> !o_execution_enable && !o_core_clock_en) else $error("Sleep not taken.");
    prescale_load_a: assert property (o_execution_enable && i_prescale_write
        && i_prescale_value <= 4'h8 |=> o_prescaler_select_field == $past(i_prescale_value))
        else $error("Prescale not loaded.");
    prescale_refuse_a: assert property (o_execution_enable && i_prescale_write
        && i_prescale_value > 4'h8 |=> $stable(o_prescaler_select_field)) else $error("Bad code taken.");
    trim_mask_a: assert property (o_execution_enable && i_trim_write
        |=> o_oscillator_trim_register == ($past(i_trim_value) & 8'h7F)) else $error("Trim wrong.");
    source_stable_a: assert property (o_execution_enable |-> $stable(o_selected_source))
        else $error("Source changed in run.");
endmodule // clock_startup_control_checker
bind clock_startup_control clock_startup_control_checker #(
    .SHORT_TIMEOUT_CYCLES(SHORT_TIMEOUT_CYCLES),
    .LONG_TIMEOUT_CYCLES(LONG_TIMEOUT_CYCLES)
) i_clock_startup_control_checker (.*);

// ### sim/clock_startup_control_tb_top.sv
// Self-checking testbench for the clock source and start-up controller.
`timescale 1ns/100ps
module clock_startup_control_tb_top;
    import clock_startup_pkg::*;
    // ------------------------------------------------------------------------
    // Settings and wiring
    // ------------------------------------------------------------------------
    // Short time-outs keep every start-up within a few hundred cycles.
    localparam int SHORT_N = 4;
    localparam int LONG_N = 16;
    localparam int WD_P = 10;
    localparam int EXT_P = 8;
    localparam int INT_P = 6;
    localparam int LOW_P = 14;
    logic i_clk, i_rst, i_fuse_valid, i_divide_by_eight_fuse, i_reset_pin_disable_fuse;
    logic [1:0] i_clock_source_select_fuses, i_startup_time_fuses;
    logic [7:0] i_calibration_byte_full, i_calibration_byte_half, i_trim_value;
    logic i_sleep_request, i_wake_event, i_converter_keep_running, i_prescale_write;
    logic i_trim_write;
    logic [3:0] i_prescale_value;
    logic i_external_clock_input, i_internal_oscillator, i_low_freq_oscillator;
    logic i_watchdog_oscillator;
    logic o_core_clock_en, o_peripheral_clock_en, o_program_memory_clock_en;
    logic o_converter_clock_en, o_execution_enable;
    logic [1:0] o_selected_source;
    logic [3:0] o_prescaler_select_field;
    logic [7:0] o_oscillator_trim_register;
    int n_errors;
    int n_compared;
    int cyc;
    clock_startup_control #(.SHORT_TIMEOUT_CYCLES(SHORT_N), .LONG_TIMEOUT_CYCLES(LONG_N))
        i_clock_startup_control (.*);
    osc_source_model #(.EXT_HALF_NS(EXT_P * 10), .INT_HALF_NS(INT_P * 10),
        .LOW_HALF_NS(LOW_P * 10), .WDT_HALF_NS(WD_P * 10)) i_osc_source_model (
        .o_external_clock_input(i_external_clock_input),
        .o_internal_oscillator(i_internal_oscillator),
        .o_low_freq_oscillator(i_low_freq_oscillator),
        .o_watchdog_oscillator(i_watchdog_oscillator));
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("Errors %0d, comparisons %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wait_for(input logic core, output int n);
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
            if (n > 4000) begin
                n_errors++;
                $display("CHECK FAILED at %0t: wait timed out", $time);
                report_and_stop();
            end
        end while ((core ? o_core_clock_en : o_execution_enable) !== 1'b1);
    endtask
    task automatic write_ctl(input logic trim, input logic [7:0] v);
        i_prescale_write = !trim;
        i_trim_write = trim;
        i_prescale_value = v[3:0];
        i_trim_value = v;
        @(negedge i_clk);
        i_prescale_write = 1'b0;
        i_trim_write = 1'b0;
    endtask
    task automatic sleep_wake(input logic keep, input int sp);
        int conv_n;
        int core_n;
        conv_n = 0;
        core_n = 0;
        i_converter_keep_running = keep;
        i_sleep_request = 1'b1;
        @(negedge i_clk);
        i_sleep_request = 1'b0;
        check(16'(o_execution_enable), 16'h0, "sleep entry");
        repeat (300) begin
            @(negedge i_clk);
            conv_n += int'(o_converter_clock_en);
            core_n += int'(o_core_clock_en);
        end
        check(16'(core_n), 16'h0, "core in sleep");
        check(16'(conv_n > 0), 16'(keep), "converter in sleep");
        i_wake_event = 1'b1;
        @(negedge i_clk);
        i_wake_event = 1'b0;
        i_converter_keep_running = 1'b0;
        wait_for(1'b0, cyc);
        check(16'(cyc >= 5 * sp && cyc <= 7 * sp + 8), 16'h1, "wake time");
    endtask
    task automatic start(input logic v, input logic [1:0] s, input logic [1:0] u,
                         input logic d, input logic r);
        int n;
        int sp;
        int lo;
        @(negedge i_clk);
        i_rst = 1'b1;
        i_fuse_valid = v;
        i_clock_source_select_fuses = s;
        i_startup_time_fuses = u;
        i_divide_by_eight_fuse = d;
        i_reset_pin_disable_fuse = r;
        repeat (6) @(negedge i_clk);
        i_rst = 1'b0;
        if (!v) begin
            s = 2'h2;
            u = 2'h2;
            d = 1'b0;
            r = 1'b1;
        end
        sp = (s == 2'h0) ? EXT_P : (s == 2'h1) ? 2 * INT_P : (s == 2'h2) ? INT_P : LOW_P;
        n = (u == 2'h0) ? ((s != 2'h0 && !r) ? SHORT_N : 0) : (u == 2'h1) ? SHORT_N : LONG_N;
        lo = (n > 0 ? (n - 1) * WD_P : 0) + 13 * sp;
        wait_for(1'b0, cyc);
        check(16'(cyc >= lo && cyc <= (n + 1) * WD_P + 15 * sp + 12), 16'h1, "start-up");
        check(16'(o_selected_source), 16'(s), "source");
        check(16'(o_prescaler_select_field), d ? 16'h0 : 16'h3, "prescale reset");
        check(16'(o_oscillator_trim_register), 16'h5A, "trim load");
        sleep_wake(u[0], sp);
    endtask
    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        n_errors = 0;
        n_compared = 0;
        {i_rst, i_fuse_valid, i_divide_by_eight_fuse, i_reset_pin_disable_fuse} = 4'hF;
        {i_clock_source_select_fuses, i_startup_time_fuses} = 4'h0;
        i_calibration_byte_full = 8'h5A;
        i_calibration_byte_half = 8'h33;
        {i_sleep_request, i_wake_event, i_converter_keep_running} = 3'h0;
        {i_prescale_write, i_trim_write, i_prescale_value, i_trim_value} = 14'h0;
        start(1'b0, 2'h0, 2'h0, 1'b1, 1'b1);
        for (int k = 0; k < 9; k++) begin
            write_ctl(1'b0, 8'(k));
            check(16'(o_prescaler_select_field), 16'(k), "prescale field");
            repeat (3) wait_for(1'b1, cyc);
            check(16'(cyc), 16'((1 << k) * INT_P), "divided period");
            check({13'h0, o_peripheral_clock_en, o_program_memory_clock_en,
                   o_converter_clock_en}, 16'h7, "enables agree");
        end
        write_ctl(1'b0, 8'h09);
        check(16'(o_prescaler_select_field), 16'h8, "reserved prescale");
        write_ctl(1'b1, 8'hFF);
        check(16'(o_oscillator_trim_register), 16'h7F, "trim write");
        // Bench oscillators are slow, so divide-by-eight is safe here; it is programmed whenever s[0] equals t[0].
        for (int s = 0; s < 4; s++) begin
            for (int t = 0; t < 4; t++) begin
                for (int r = 0; r < 2; r++) begin
                    start(1'b1, 2'(s), 2'(t), s[0] ^ t[0], r[0]);
                end
            end
        end
        report_and_stop();
    end
endmodule // clock_startup_control_tb_top
